//--- common/tbr_pkg.sv
// Package with register map, field positions and reset values of the time-base unit
package tbr_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] TBR_OFS_CTRL1 = 8'h00; // control_register_one
	localparam logic [7:0] TBR_OFS_SMODE = 8'h08; // slave mode / clock source
	localparam logic [7:0] TBR_OFS_INTEN = 8'h0C; // interrupt enable
	localparam logic [7:0] TBR_OFS_STAT = 8'h10; // sticky status, read only
	localparam logic [7:0] TBR_OFS_EVGEN = 8'h14; // event generation, write only
	localparam logic [7:0] TBR_OFS_CLR = 8'h18; // status clear, write only
	localparam logic [7:0] TBR_OFS_CNT = 8'h24; // counter_value
	localparam logic [7:0] TBR_OFS_PSC = 8'h28; // prescale_value
	localparam logic [7:0] TBR_OFS_RLD = 8'h2C; // reload_value
	localparam logic [7:0] TBR_OFS_REP = 8'h30; // repetition_count

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TBR_CTRL1_EN = 0; // counter enable
	localparam int TBR_CTRL1_UPDIS = 1; // update_disable
	localparam int TBR_CTRL1_DIR = 4; // count_direction_bit, 1 = down
	localparam int TBR_CTRL1_CMS = 5; // 1 = center-aligned
	localparam int TBR_ST_UPD = 0; // update event
	localparam int TBR_ST_TRG = 1; // trigger event
	localparam int TBR_ST_CC = 2; // capture/compare event
	localparam int TBR_ST_BRK = 3; // break event
	localparam int TBR_NEV = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] TBR_RST_RLD = 16'hFFFF;
	localparam logic [15:0] TBR_RST_PSC = 16'h0000;
	localparam logic [7:0] TBR_RST_REP = 8'h00;

	// Clock source selection
	typedef enum logic [1:0] {
		TBR_SRC_INT,
		TBR_SRC_EXT1,
		TBR_SRC_ITR
	} tbr_src_t;

	// Slave reaction to the master trigger
	typedef enum logic [1:0] {
		TBR_SLV_NONE,
		TBR_SLV_RESET,
		TBR_SLV_GATE,
		TBR_SLV_START
	} tbr_slv_t;
endpackage

//--- design/tbr_presc.sv
// Buffered 16-bit prescaler producing a one-cycle counter clock enable
`timescale 1ns/1ps
module tbr_presc import tbr_pkg::*; #(
	parameter int W = 16
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic tick_in, // prescaler_input_clock pulse
	input wire logic [W-1:0] ratio_act, // active division factor minus one
	input wire logic restart, // clear internal count
	output logic cnt_tick // counter_clock pulse
);
	logic [W-1:0] div_r;

	// ****************************************
	// Divider
	// ****************************************
	// divide by ratio plus one
	always_ff @(posedge clk) begin
		if (rst || restart) begin
			div_r <= '0;
		end else if (tick_in) begin
			div_r <= (div_r >= ratio_act) ? '0 : div_r + W'(1);
		end
	end

	// Combinational so ratio 0 passes every input pulse
	assign cnt_tick = tick_in && !restart && (div_r >= ratio_act);
endmodule

//--- design/tbr_timebase.sv
// Time-base unit: counter, prescaler, reload and repetition counter on APB
//
// How it works
// - 16-bit counter counts up or down per direction bit, or center-aligned per its own bit.
// - Up mode starts at zero, adds one, wraps at reload with overrun.
// - Update event copies repetition, reload and prescale preloads together.
// - Update-disable bit blocks update events and all shadow transfers.
// - Each overrun or underrun decrements repetition unless update-disable is set; update only at zero.
// - Repetition value N gives one update per N+1 wraps.
// - Repetition register is 8 bits; 16-bit claim elsewhere needs confirming.
// - Prescaler divides its input clock by prescale value plus one.
// - Prescale writes are buffered and applied only at an update event.
// - With internal source, or trigger source plus a slave action, the prescaler input is the internal clock.
// - External mode one counts polarity-selected filtered channel or both edges.
// - Internal trigger source without slave action clocks from another timer, unfiltered.
// - Master trigger can reset, gate, start or clock this slave.
// - Update, trigger, capture/compare and break events raise interrupts.
// - Software update clears prescaler count, loads counter per direction.
`timescale 1ns/1ps
module tbr_timebase import tbr_pkg::*; #(
	parameter int CW = 16, // counter width
	parameter int RW = 8, // repetition width
	parameter int FLT = 4 // channel filter length in samples
) (
	input wire logic clk, // 10 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic ch1_in, // input channel 1 level
	input wire logic ch2_in, // input channel 2 level
	input wire logic itr_in, // other timer trigger output
	input wire logic cc_evt, // capture/compare event pulse
	input wire logic brk_evt, // break input event pulse
	output logic trg_out, // master trigger output pulse
	output logic irq // level interrupt
);
	// ****************************************
	// Registers
	// ****************************************
	logic [5:0] ctrl1_r;
	logic [7:0] smode_r;
	logic [TBR_NEV-1:0] inten_r, stat_r;
	logic [CW-1:0] cnt_r, psc_pre_r, psc_act_r, rld_pre_r, rld_act_r;
	logic [RW-1:0] rep_pre_r, rep_cnt_r;
	logic down_r;
	logic [FLT-1:0] flt_r;
	logic ch_f_r, ch_prev_r, itr_prev_r;
	logic [31:0] rdata_nxt;
	logic wr, rd, hit, sw_upd, cnt_tick, tick_in, wrap, upd_evt, trg_evt;
	logic ext_edge, itr_edge, ch_sel, run;
	tbr_src_t src;
	tbr_slv_t slv;

	// Address decode used by the write path and the error response
	function automatic logic is_reg(input logic [7:0] a);
		case (a)
			TBR_OFS_CTRL1, TBR_OFS_SMODE, TBR_OFS_INTEN, TBR_OFS_STAT, TBR_OFS_EVGEN,
			TBR_OFS_CLR, TBR_OFS_CNT, TBR_OFS_PSC, TBR_OFS_RLD, TBR_OFS_REP: is_reg = 1'b1;
			default: is_reg = 1'b0;
		endcase
	endfunction

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign hit = is_reg(paddr);
	assign pslverr = psel && penable && !hit;
	assign wr = psel && penable && pwrite && hit;
	assign rd = psel && !penable && !pwrite;
	assign sw_upd = wr && paddr == TBR_OFS_EVGEN && pwdata[0];

	// smode: [1:0] source, [2] polarity, [3] both edges, [4] channel 2, [6:5] slave action
	assign src = tbr_src_t'(smode_r[1:0]);
	assign slv = tbr_slv_t'(smode_r[6:5]);

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl1_r <= '0;
			smode_r <= '0;
			inten_r <= '0;
			psc_pre_r <= TBR_RST_PSC;
			rld_pre_r <= TBR_RST_RLD;
			rep_pre_r <= TBR_RST_REP;
		end else if (wr) begin
			case (paddr)
				TBR_OFS_CTRL1: ctrl1_r <= pwdata[5:0];
				TBR_OFS_SMODE: smode_r <= pwdata[7:0];
				TBR_OFS_INTEN: inten_r <= pwdata[TBR_NEV-1:0];
				TBR_OFS_PSC: psc_pre_r <= pwdata[CW-1:0];
				TBR_OFS_RLD: rld_pre_r <= pwdata[CW-1:0];
				TBR_OFS_REP: rep_pre_r <= pwdata[RW-1:0];
				default: ;
			endcase
		end
		// Master start action sets the enable bit
		if (!rst && trg_evt && slv == TBR_SLV_START) begin
			ctrl1_r[TBR_CTRL1_EN] <= 1'b1;
		end
	end

	// ****************************************
	// Clock source selection
	// ****************************************
	// polarity-selected filtered channel
	always_ff @(posedge clk) begin
		if (rst) begin
			flt_r <= '0;
			ch_f_r <= 1'b0;
			ch_prev_r <= 1'b0;
			itr_prev_r <= 1'b0;
		end else begin
			flt_r <= {flt_r[FLT-2:0], ch_sel};
			if (&flt_r) begin
				ch_f_r <= 1'b1;
			end else if (~|flt_r) begin
				ch_f_r <= 1'b0;
			end
			ch_prev_r <= ch_f_r;
			itr_prev_r <= itr_in;
		end
	end

	assign ch_sel = (smode_r[4] ? ch2_in : ch1_in) ^ smode_r[2];
	// Both-edge mode gives both edges of the selected filtered channel
	assign ext_edge = smode_r[3] ? (ch_f_r ^ ch_prev_r) : (ch_f_r && !ch_prev_r);
	assign itr_edge = itr_in && !itr_prev_r;
	assign trg_evt = (src == TBR_SRC_ITR) ? itr_edge : (src == TBR_SRC_EXT1 ? ext_edge : 1'b0);

	always_comb begin
		case (src)
			TBR_SRC_EXT1: tick_in = ext_edge;
			TBR_SRC_ITR: tick_in = (slv == TBR_SLV_NONE) ? itr_edge : 1'b1;
			default: tick_in = 1'b1;
		endcase
	end

	// Gated slave mode counts only while the master level is high
	// gate, reset, start
	assign run = ctrl1_r[TBR_CTRL1_EN] && !(slv == TBR_SLV_GATE && !itr_in);

	tbr_presc #(.W(CW)) u_presc (
		.clk(clk),
		.rst(rst),
		.tick_in(tick_in && run),
		.ratio_act(psc_act_r),
		.restart(sw_upd || (trg_evt && slv == TBR_SLV_RESET)),
		.cnt_tick(cnt_tick)
	);

	// ****************************************
	// Counter
	// ****************************************
	// Zero reload stops counting, as an empty reload should
	always_comb begin
		wrap = 1'b0;
		if (cnt_tick && rld_act_r != '0) begin
			if (ctrl1_r[TBR_CTRL1_CMS]) begin
				wrap = down_r ? (cnt_r == CW'(1)) : (cnt_r == rld_act_r - CW'(1));
			end else if (ctrl1_r[TBR_CTRL1_DIR]) begin
				wrap = (cnt_r == '0);
			end else begin
				wrap = (cnt_r == rld_act_r);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			down_r <= 1'b0;
		end else if (sw_upd || (trg_evt && slv == TBR_SLV_RESET)) begin
			// load or clear counter
			// Take the new reload when this same update refreshes the shadow
			cnt_r <= (ctrl1_r[TBR_CTRL1_DIR] && !ctrl1_r[TBR_CTRL1_CMS])
				? (upd_evt ? rld_pre_r : rld_act_r) : '0;
			down_r <= 1'b0;
		end else if (wr && paddr == TBR_OFS_CNT) begin
			cnt_r <= pwdata[CW-1:0];
		end else if (cnt_tick && rld_act_r != '0) begin
			if (ctrl1_r[TBR_CTRL1_CMS]) begin
				if (wrap) begin
					down_r <= !down_r;
				end
				cnt_r <= down_r ? cnt_r - CW'(1) : cnt_r + CW'(1);
			end else if (ctrl1_r[TBR_CTRL1_DIR]) begin
				cnt_r <= wrap ? rld_act_r : cnt_r - CW'(1);
			end else begin
				cnt_r <= wrap ? '0 : cnt_r + CW'(1);
			end
		end
	end

	// ****************************************
	// Repetition and shadow transfer
	// ****************************************
	// update disable
	assign upd_evt = !ctrl1_r[TBR_CTRL1_UPDIS] && (sw_upd || (wrap && rep_cnt_r == '0));

	always_ff @(posedge clk) begin
		if (rst) begin
			rep_cnt_r <= TBR_RST_REP;
			rld_act_r <= TBR_RST_RLD;
			psc_act_r <= TBR_RST_PSC;
		end else if (upd_evt) begin
			rep_cnt_r <= rep_pre_r;
			rld_act_r <= rld_pre_r;
			psc_act_r <= psc_pre_r;
		end else if (wrap && !ctrl1_r[TBR_CTRL1_UPDIS]) begin
			rep_cnt_r <= rep_cnt_r - RW'(1);
		end
	end

	// Master output: one pulse per update event
	always_ff @(posedge clk) begin
		if (rst) begin
			trg_out <= 1'b0;
		end else begin
			trg_out <= upd_evt;
		end
	end

	// ****************************************
	// Interrupt status
	// ****************************************
	// sticky events, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~((wr && paddr == TBR_OFS_CLR) ? pwdata[TBR_NEV-1:0] : '0))
				| {brk_evt, cc_evt, trg_evt, upd_evt};
		end
	end

	assign irq = |(stat_r & inten_r);

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rdata_nxt = '0;
		case (paddr)
			TBR_OFS_CTRL1: rdata_nxt[5:0] = ctrl1_r;
			TBR_OFS_SMODE: rdata_nxt[7:0] = smode_r;
			TBR_OFS_INTEN: rdata_nxt[TBR_NEV-1:0] = inten_r;
			TBR_OFS_STAT: rdata_nxt[TBR_NEV-1:0] = stat_r;
			TBR_OFS_CNT: rdata_nxt[CW-1:0] = cnt_r;
			TBR_OFS_PSC: rdata_nxt[CW-1:0] = psc_pre_r;
			TBR_OFS_RLD: rdata_nxt[CW-1:0] = rld_pre_r;
			TBR_OFS_REP: rdata_nxt[RW-1:0] = rep_pre_r;
			default: rdata_nxt = '0;
		endcase
	end

	// Captured in setup so data is registered for the access phase
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= '0;
		end else if (rd) begin
			prdata <= rdata_nxt;
		end
	end
endmodule

//--- dv/tbr_timebase_checker.sv
// Port-level assertions for the time-base unit
`timescale 1ns/1ps
module tbr_timebase_checker import tbr_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic cc_evt, // cc event
	input wire logic brk_evt, // break event
	input wire logic trg_out, // trigger pulse
	input wire logic irq // interrupt
);
	logic [3:0] ien_r;
	logic acc;
	logic map;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Access phase and address decode
	assign acc = psel && penable;
	assign map = paddr inside {TBR_OFS_CTRL1, TBR_OFS_SMODE, TBR_OFS_INTEN, TBR_OFS_STAT,
		TBR_OFS_EVGEN, TBR_OFS_CLR, TBR_OFS_CNT, TBR_OFS_PSC, TBR_OFS_RLD, TBR_OFS_REP};
	// Enable shadow rebuilt from bus writes, the real one is hidden
	always_ff @(posedge clk) begin
		if (rst) begin
			ien_r <= '0;
		end else if (acc && pwrite && paddr == TBR_OFS_INTEN) begin
			ien_r <= pwdata[3:0];
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_err_unmap: assert property (acc && !map |-> pslverr)
		else $error("no error on unmapped access");
	chk_err_map: assert property (acc && map |-> !pslverr)
		else $error("error on mapped access");
	chk_rd_unmap: assert property (acc && !pwrite && !map |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_rd_upper: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_cc_irq: assert property (cc_evt && ien_r[2] ##1 ien_r[2] |-> irq)
		else $error("cc event raised no interrupt");
	chk_brk_irq: assert property (brk_evt && ien_r[3] ##1 ien_r[3] |-> irq)
		else $error("break event raised no interrupt");
	chk_upd_irq: assert property (trg_out && ien_r[0] |-> irq)
		else $error("update raised no interrupt");
	chk_irq_fall: assert property ($fell(irq) |-> $past(rst) || $past(acc && pwrite
		&& (paddr == TBR_OFS_CLR || paddr == TBR_OFS_INTEN)))
		else $error("interrupt dropped without clear");
	chk_rst_quiet: assert property (disable iff (1'b0) rst |=> !irq && !trg_out && prdata == 0)
		else $error("outputs active after reset");
	// Main scenarios seen
	cover property (trg_out);
	cover property ($rose(irq));
	cover property (acc && pslverr);
endmodule
bind tbr_timebase tbr_timebase_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cc_evt(cc_evt), .brk_evt(brk_evt),
	.trg_out(trg_out), .irq(irq));

//--- dv/tbr_timebase_tb_top.sv
// Self-checking bench for the time-base unit
`timescale 1ns/1ps
module tbr_timebase_tb_top import tbr_pkg::*;;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cc_evt = 0, brk_evt = 0;
	logic ch1_in = 0, ch2_in = 0, itr_in = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, s = 32'h0000_7dba;
	logic pready, pslverr, trg_out, irq, e;
	int n_mismatch = 0, tests_run = 0, cyc = 0, r, n, p, d, x, ex, k, cm;
	logic [7:0] ra[5] = '{TBR_OFS_PSC, TBR_OFS_RLD, TBR_OFS_REP, TBR_OFS_CNT, TBR_OFS_STAT};
	logic [31:0] rv[5] = '{0, 32'h0000_FFFF, 0, 0, 0};
	tbr_timebase dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch1_in(ch1_in), .ch2_in(ch2_in), .itr_in(itr_in), .cc_evt(cc_evt), .brk_evt(brk_evt),
		.trg_out(trg_out), .irq(irq));
	// 10 MHz clock
	initial begin
		forever #50 clk = ~clk;
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd);
		// Idle cycle after a transfer so psel never falls and rises in one step
		if (psel)
			@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Cycles until the next update pulse, capped at lim
	task automatic wt(input int lim, output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (trg_out !== 1'b1 && k < lim);
	endtask
	// Channel 1 pulses of hi cycles then 8 low; channel 2 stays high during glitches
	task automatic edges(input int n, input int hi);
		ch2_in <= (hi == 1);
		repeat (n) begin
			ch1_in <= 1;
			repeat (hi) @(posedge clk);
			ch1_in <= 0;
			repeat (8) @(posedge clk);
		end
		ch2_in <= 0;
	endtask
	task automatic give_verdict;
		$display("Checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		foreach (ra[i]) begin
			bus(0, ra[i], 0);
			chk("reset value", q, rv[i]);
		end
		bus(1, TBR_OFS_REP, 32'h0000_01FF);
		bus(0, TBR_OFS_REP, 0);
		chk("rep width", q, 32'h0000_00FF);
		bus(0, 8'h04, 0);
		chk("unmapped err", e, 1);
		chk("unmapped data", q, 0);
		bus(1, TBR_OFS_STAT, 32'h0000_000F);
		bus(0, TBR_OFS_STAT, 0);
		chk("status ro", q, 0);
		bus(1, TBR_OFS_RLD, 5);
		bus(1, TBR_OFS_EVGEN, 1);
		bus(0, TBR_OFS_CNT, 0);
		chk("swu up", q, 0);
		bus(1, TBR_OFS_CTRL1, 32'h0000_0010);
		bus(1, TBR_OFS_EVGEN, 1);
		bus(0, TBR_OFS_CNT, 0);
		chk("swu down", q, 5);
		bus(1, TBR_OFS_INTEN, 1);
		// random periods; short values keep the run brief
		repeat (4) begin
			r = xs() % 6 + 1;
			n = xs() % 4;
			p = xs() % 3;
			d = xs() % 3;
			cm = (d == 2) ? 32'h0000_0020 : d << 4;
			ex = (p + 1) * (r + (d != 2)) * (n + 1);
			bus(1, TBR_OFS_CTRL1, cm);
			bus(1, TBR_OFS_RLD, r);
			bus(1, TBR_OFS_REP, n);
			bus(1, TBR_OFS_PSC, p);
			bus(1, TBR_OFS_EVGEN, 1);
			bus(1, TBR_OFS_CTRL1, 1 + cm);
			wt(999, x);
			wt(999, x);
			chk("period", x, ex);
			chk("update irq", irq, 1);
			wt(999, x);
			chk("period again", x, ex);
			bus(1, TBR_OFS_PSC, p + 1);
			wt(999, x);
			chk("old ratio", x + 2, ex);
			wt(999, x);
			chk("new ratio", x, ex / (p + 1) * (p + 2));
			bus(1, TBR_OFS_CTRL1, 3 + cm);
			wt(3 * ex, x);
			chk("no update", x, 3 * ex);
		end
		bus(1, TBR_OFS_CTRL1, 0);
		bus(1, TBR_OFS_CLR, 32'h0000_000F);
		@(posedge clk);
		chk("irq cleared", irq, 0);
		for (int b = 2; b < 4; b++) begin
			bus(1, TBR_OFS_INTEN, 0);
			if (b == 2)
				cc_evt <= 1;
			else
				brk_evt <= 1;
			@(posedge clk);
			cc_evt <= 0;
			brk_evt <= 0;
			@(posedge clk);
			chk("masked", irq, 0);
			bus(0, TBR_OFS_STAT, 0);
			chk("sticky", q, 1 << b);
			bus(1, TBR_OFS_INTEN, 1 << b);
			@(posedge clk);
			chk("enabled", irq, 1);
			bus(1, TBR_OFS_CLR, 1 << b);
			@(posedge clk);
			chk("cleared", irq, 0);
			cc_evt <= (b == 2);
			brk_evt <= (b == 3);
			@(posedge clk);
			cc_evt <= 0;
			brk_evt <= 0;
			@(posedge clk);
			chk("live", irq, 1);
			bus(1, TBR_OFS_CLR, 1 << b);
		end
		// filtered channel 1 clocks the counter, glitches ignored
		bus(1, TBR_OFS_RLD, 32'h0000_0100);
		bus(1, TBR_OFS_PSC, 0);
		bus(1, TBR_OFS_EVGEN, 1);
		bus(1, TBR_OFS_SMODE, 1);
		bus(1, TBR_OFS_CTRL1, 1);
		k = xs() % 5 + 2;
		edges(k, 8);
		edges(2, 1);
		bus(0, TBR_OFS_CNT, 0);
		chk("ext rising", q, k);
		bus(1, TBR_OFS_SMODE, 9);
		edges(k, 8);
		bus(0, TBR_OFS_CNT, 0);
		chk("ext both edges", q, 3 * k);
		// single-cycle trigger pulses count, no filter
		bus(1, TBR_OFS_SMODE, 2);
		repeat (k) begin
			itr_in <= 1;
			@(posedge clk);
			itr_in <= 0;
			@(posedge clk);
		end
		bus(0, TBR_OFS_CNT, 0);
		chk("itr count", q, 4 * k);
		// master trigger starts, gates and resets this slave
		bus(1, TBR_OFS_CTRL1, 0);
		bus(1, TBR_OFS_SMODE, 32'h0000_0062);
		itr_in <= 1;
		@(posedge clk);
		itr_in <= 0;
		bus(0, TBR_OFS_CTRL1, 0);
		chk("slave start", q, 1);
		bus(1, TBR_OFS_SMODE, 32'h0000_0042);
		bus(1, TBR_OFS_CNT, 0);
		itr_in <= 1;
		repeat (k) @(posedge clk);
		itr_in <= 0;
		bus(0, TBR_OFS_CNT, 0);
		chk("slave gate", q, k);
		bus(1, TBR_OFS_SMODE, 32'h0000_0022);
		repeat (20) @(posedge clk);
		itr_in <= 1;
		@(posedge clk);
		itr_in <= 0;
		bus(0, TBR_OFS_CNT, 0);
		chk("slave reset", q, 0);
		give_verdict;
	end
endmodule
